// *** src/dac_cfg_pkg.sv ***
// constants for the output configuration and slew block
// assumes a 50 MHz system clock and a 24-bit serial frame
package dac_cfg_pkg;
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] CFG_ADDR = 5'h06;
    localparam logic [23:0] CFG_RESET_WORD = 24'h06_0C00;
    localparam int READ_BIT = 23;
    localparam int FAULT_BIT = 21;
    localparam int ADDR_HI = 20;
    localparam int ADDR_LO = 16;
    localparam int STEP_HI = 15;
    localparam int STEP_LO = 13;
    localparam int RATE_HI = 12;
    localparam int RATE_LO = 9;
    localparam int SLEW_ON_BIT = 8;
    localparam int RSET_BIT = 7;
    localparam int OUT_EN_BIT = 6;
    localparam int BUF_PWR_BIT = 5;
    localparam int OVRNG_BIT = 4;
    localparam int RANGE_HI = 3;
    localparam int RANGE_LO = 0;
    localparam int CODE_W = 16;
    localparam int DIV_W = 24;
    localparam int CLK_HZ_DEFAULT = 50_000_000;
    localparam int CAL_REFRESH_CYCLES_DEFAULT = 1000;

    function automatic logic [CODE_W-1:0] step_lsb(input logic [2:0] code);
        logic [CODE_W-1:0] s;
        s = 16'h0004;
        case (code)
            3'h0: s = 16'h0004;
            3'h1: s = 16'h000C;
            3'h2: s = 16'h0040;
            3'h3: s = 16'h0078;
            3'h4: s = 16'h0100;
            3'h5: s = 16'h01F4;
            3'h6: s = 16'h071C;
            default: s = 16'h0800;
        endcase
        return s;
    endfunction

    function automatic int rate_hz(input logic [3:0] code);
        int f;
        f = 16000;
        case (code)
            4'h0: f = 240000;
            4'h1: f = 200000;
            4'h2: f = 150000;
            4'h3: f = 128000;
            4'h4: f = 64000;
            4'h5: f = 32000;
            4'h6: f = 16000;
            4'h7: f = 8000;
            4'h8: f = 4000;
            4'h9: f = 2000;
            4'hA: f = 1000;
            4'hB: f = 512;
            4'hC: f = 256;
            4'hD: f = 128;
            4'hE: f = 64;
            default: f = 16;
        endcase
        return f;
    endfunction
endpackage

// *** src/slew_if.sv ***
// carrier between the register block and the slew engine
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface slew_if;
    logic [2:0] step_code;
    logic [3:0] rate_code;
    logic slew_on;
    logic [15:0] target;
    logic target_load;
    logic clear_event;
    logic immediate_clear;
    logic [15:0] clear_code;
    logic [15:0] dac_code;
    modport cfg (output step_code, rate_code, slew_on, target, target_load,
                 output clear_event, immediate_clear, clear_code, input dac_code);
    modport eng (input step_code, rate_code, slew_on, target, target_load,
                 input clear_event, immediate_clear, clear_code, output dac_code);
endinterface

// *** src/slew_engine.sv ***
// digital slew engine: steps the working code toward the held target
// assumes clk at CLK_HZ and synchronous active-low reset
`timescale 1ns/1ps
module slew_engine #(
    parameter int CLK_HZ = dac_cfg_pkg::CLK_HZ_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    slew_if.eng s
);
    localparam int DW = dac_cfg_pkg::DIV_W;

    logic [dac_cfg_pkg::DIV_W-1:0] div_ff, nxt_div;
    logic [15:0] held_ff, nxt_held;
    logic [15:0] code_ff, nxt_code;
    logic [dac_cfg_pkg::DIV_W-1:0] div_end;
    logic tick;
    logic [15:0] step;
    logic [15:0] gap;

    assign s.dac_code = code_ff;

    always_comb begin
        div_end = DW'(CLK_HZ / dac_cfg_pkg::rate_hz(s.rate_code) - 1);
        tick = (div_ff >= div_end);
        nxt_div = tick ? '0 : div_ff + 1'b1;
        step = dac_cfg_pkg::step_lsb(s.step_code);
        nxt_held = held_ff;
        nxt_code = code_ff;
        gap = '0;
        if (s.clear_event) begin
            nxt_held = s.clear_code;
        end else if (s.target_load) begin
            nxt_held = s.target;
        end
        if (s.clear_event && s.immediate_clear) begin
            nxt_code = s.clear_code;
        end else if (!s.slew_on) begin
            nxt_code = held_ff;
        end else if (tick) begin
            if (held_ff > code_ff) begin
                gap = held_ff - code_ff;
                nxt_code = (gap <= step) ? held_ff : code_ff + step;
            end else if (held_ff < code_ff) begin
                gap = code_ff - held_ff;
                nxt_code = (gap <= step) ? held_ff : code_ff - step;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_ff <= '0;
            held_ff <= '0;
            code_ff <= '0;
        end else begin
            div_ff <= nxt_div;
            held_ff <= nxt_held;
            code_ff <= nxt_code;
        end
    end
endmodule

// *** src/dac_output_config_slew.sv ***
// serial configuration register of the output DAC with slew control
// assumes serial pins synchronous to clk and sclk well below clk/4
//
// Functional notes
// - config register resets to 0x060C00, address 0x06, rate code 6.
// - readback bit 21 is live fault pin, bits 20:16 the address.
// - step field 15:13 picks 4 to 2048 LSB per slew update.
// - rate field 12:9 picks update rate, 240 kHz down to 16 Hz.
// - bit 8 turns slew limiting on; default off.
// - bit 7 selects external set resistor; clear selects internal.
// - bit 6 enables the output terminal; default disabled.
// - bit 5 powers converter core and amplifiers, not the output.
// - bit 4 enables 20 percent voltage overrange; default off.
// - bits 3:0 select output range; voltage low, current 1000-1101.
// - changing range starts calibration refresh, flagged pending until done.
// - immediate clear loads clear code at once, bypassing slew.
`timescale 1ns/1ps
module dac_output_config_slew #(
    parameter int CLK_HZ = dac_cfg_pkg::CLK_HZ_DEFAULT,
    parameter int CAL_REFRESH_CYCLES = dac_cfg_pkg::CAL_REFRESH_CYCLES_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdi,
    output logic sdo,
    input wire logic fault_pin_level,
    input wire logic [15:0] target_code,
    input wire logic target_load,
    input wire logic clear_event,
    input wire logic immediate_clear_on,
    input wire logic [15:0] clear_code,
    output logic [15:0] dac_code,
    output logic [2:0] slew_step_size,
    output logic [3:0] slew_update_rate,
    output logic slew_limit_on,
    output logic external_set_resistor_sel,
    output logic output_enable,
    output logic buffer_power_up,
    output logic voltage_overrange_on,
    output logic [3:0] output_range,
    output logic calibration_refresh_pending
);
    localparam int FB = dac_cfg_pkg::FRAME_BITS;
    localparam logic [4:0] FRAME_CNT = 5'(dac_cfg_pkg::FRAME_BITS);
    localparam logic [15:0] CFG_RESET = dac_cfg_pkg::CFG_RESET_WORD[15:0];
    localparam int RW = $clog2(CAL_REFRESH_CYCLES + 1);

    logic sclk_d_ff, nxt_sclk_d;
    logic sync_d_ff, nxt_sync_d;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [FB-1:0] rx_ff, nxt_rx;
    logic [FB-1:0] tx_ff, nxt_tx;
    logic [15:0] cfg_ff, nxt_cfg;
    logic pend_ff, nxt_pend;
    logic [RW-1:0] ref_ff, nxt_ref;
    logic sclk_rise, sclk_fall, frame_end;
    logic [4:0] addr;
    logic [15:0] rd_data;

    slew_if sif ();

    assign sif.step_code = cfg_ff[dac_cfg_pkg::STEP_HI:dac_cfg_pkg::STEP_LO];
    assign sif.rate_code = cfg_ff[dac_cfg_pkg::RATE_HI:dac_cfg_pkg::RATE_LO];
    assign sif.slew_on = cfg_ff[dac_cfg_pkg::SLEW_ON_BIT];
    assign sif.target = target_code;
    assign sif.target_load = target_load;
    assign sif.clear_event = clear_event;
    assign sif.immediate_clear = immediate_clear_on;
    assign sif.clear_code = clear_code;

    slew_engine #(
        .CLK_HZ(CLK_HZ)
    ) u_slew (
        .clk(clk),
        .rst_n(rst_n),
        .s(sif)
    );

    assign dac_code = sif.dac_code;
    assign sdo = tx_ff[FB-1];
    assign slew_step_size = cfg_ff[dac_cfg_pkg::STEP_HI:dac_cfg_pkg::STEP_LO];
    assign slew_update_rate = cfg_ff[dac_cfg_pkg::RATE_HI:dac_cfg_pkg::RATE_LO];
    assign slew_limit_on = cfg_ff[dac_cfg_pkg::SLEW_ON_BIT];
    assign external_set_resistor_sel = cfg_ff[dac_cfg_pkg::RSET_BIT];
    assign output_enable = cfg_ff[dac_cfg_pkg::OUT_EN_BIT];
    assign buffer_power_up = cfg_ff[dac_cfg_pkg::BUF_PWR_BIT];
    assign voltage_overrange_on = cfg_ff[dac_cfg_pkg::OVRNG_BIT];
    assign output_range = cfg_ff[dac_cfg_pkg::RANGE_HI:dac_cfg_pkg::RANGE_LO];
    assign calibration_refresh_pending = pend_ff;

    always_comb begin
        nxt_sclk_d = sclk;
        nxt_sync_d = sync_n;
        sclk_rise = sclk && !sclk_d_ff && !sync_n;
        sclk_fall = !sclk && sclk_d_ff && !sync_n;
        frame_end = sync_n && !sync_d_ff && (cnt_ff == FRAME_CNT);
        addr = rx_ff[dac_cfg_pkg::ADDR_HI:dac_cfg_pkg::ADDR_LO];
        rd_data = (addr == dac_cfg_pkg::CFG_ADDR) ? cfg_ff : '0;
        nxt_cnt = cnt_ff;
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        nxt_cfg = cfg_ff;
        nxt_pend = pend_ff;
        nxt_ref = ref_ff;
        if (sync_n) begin
            nxt_cnt = '0;
        end else if (sclk_rise) begin
            nxt_rx = {rx_ff[FB-2:0], sdi};
            if (cnt_ff != FRAME_CNT) begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
        if (sclk_fall) begin
            nxt_tx = {tx_ff[FB-2:0], 1'b0};
        end
        if (pend_ff) begin
            if (ref_ff == '0) begin
                nxt_pend = 1'b0;
            end else begin
                nxt_ref = ref_ff - 1'b1;
            end
        end
        if (frame_end) begin
            nxt_tx = '0;
            if (rx_ff[dac_cfg_pkg::READ_BIT]) begin
                nxt_tx[dac_cfg_pkg::FAULT_BIT] = fault_pin_level;
                nxt_tx[dac_cfg_pkg::ADDR_HI:dac_cfg_pkg::ADDR_LO] = addr;
                nxt_tx[dac_cfg_pkg::CODE_W-1:0] = rd_data;
            end else if (addr == dac_cfg_pkg::CFG_ADDR && !pend_ff) begin
                nxt_cfg = rx_ff[dac_cfg_pkg::CODE_W-1:0];
                if (rx_ff[dac_cfg_pkg::RANGE_HI:dac_cfg_pkg::RANGE_LO] !=
                    cfg_ff[dac_cfg_pkg::RANGE_HI:dac_cfg_pkg::RANGE_LO]) begin
                    nxt_pend = 1'b1;
                    nxt_ref = RW'(CAL_REFRESH_CYCLES - 1);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_d_ff <= 1'b0;
            sync_d_ff <= 1'b1;
            cnt_ff <= '0;
            rx_ff <= '0;
            tx_ff <= '0;
            cfg_ff <= CFG_RESET;
            pend_ff <= 1'b0;
            ref_ff <= '0;
        end else begin
            sclk_d_ff <= nxt_sclk_d;
            sync_d_ff <= nxt_sync_d;
            cnt_ff <= nxt_cnt;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            cfg_ff <= nxt_cfg;
            pend_ff <= nxt_pend;
            ref_ff <= nxt_ref;
        end
    end
endmodule

// *** tb/dac_cfg_checker.sv ***
// assertions on the configuration and slew block ports
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
module dac_cfg_checker #(
    parameter int CAL_REFRESH_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_n,
    input wire logic [15:0] target_code,
    input wire logic target_load,
    input wire logic clear_event,
    input wire logic immediate_clear_on,
    input wire logic [15:0] clear_code,
    input wire logic [15:0] dac_code,
    input wire logic [2:0] slew_step_size,
    input wire logic [3:0] slew_update_rate,
    input wire logic slew_limit_on,
    input wire logic [3:0] output_range,
    input wire logic calibration_refresh_pending
);
    localparam int CAL_MAX = CAL_REFRESH_CYCLES + 8;
    localparam logic [15:0] STP [8] = '{16'h0004, 16'h000C, 16'h0040, 16'h0078,
        16'h0100, 16'h01F4, 16'h071C, 16'h0800};
    logic [15:0] prev_ff;
    logic [15:0] nxt_prev;
    logic [15:0] delta;
    always_comb begin
        nxt_prev = dac_code;
        delta = (dac_code > prev_ff) ? dac_code - prev_ff : prev_ff - dac_code;
    end
    always_ff @(posedge clk) begin
        prev_ff <= nxt_prev;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RESET_VALUES: assert property (disable iff (1'b0) !rst_n ##1 rst_n |->
        slew_update_rate == 4'h6 && slew_step_size == 3'h0 && !slew_limit_on
        && output_range == 4'h0 && !calibration_refresh_pending) else $error("reset values");
    AST_CFG_AFTER_FRAME: assert property ($changed({slew_step_size, slew_update_rate,
        slew_limit_on, output_range}) |-> !$past(sync_n, 2) || !$past(sync_n, 3)
        || !$past(sync_n, 4)) else $error("config changed outside frame end");
    AST_RANGE_PENDING: assert property ($changed(output_range)
        |-> ##[0:2] calibration_refresh_pending) else $error("no refresh on range change");
    AST_PENDING_ENDS: assert property ($rose(calibration_refresh_pending)
        |-> ##[1:CAL_MAX] !calibration_refresh_pending) else $error("refresh never ends");
    AST_IMM_CLEAR: assert property (clear_event && immediate_clear_on
        |=> dac_code == $past(clear_code)) else $error("immediate clear missed");
    AST_STEP_LIMIT: assert property (slew_limit_on && $past(slew_limit_on, 2)
        && !$past(clear_event) && !$past(clear_event, 2) |-> delta <= STP[slew_step_size])
        else $error("slew step too large");
    AST_DIRECT_LOAD: assert property (target_load && !clear_event && !slew_limit_on
        |-> ##2 dac_code == $past(target_code, 2)) else $error("direct load wrong");
    AST_TICK_SPACING: assert property ($changed(dac_code) && slew_limit_on
        && $past(slew_limit_on, 2) && !$past(clear_event) |=> $stable(dac_code) [*8])
        else $error("slew ticks too close");
endmodule
bind dac_output_config_slew dac_cfg_checker #(.CAL_REFRESH_CYCLES(CAL_REFRESH_CYCLES)) chk (
    .clk(clk), .rst_n(rst_n), .sync_n(sync_n), .target_code(target_code),
    .target_load(target_load), .clear_event(clear_event),
    .immediate_clear_on(immediate_clear_on), .clear_code(clear_code), .dac_code(dac_code),
    .slew_step_size(slew_step_size), .slew_update_rate(slew_update_rate),
    .slew_limit_on(slew_limit_on), .output_range(output_range),
    .calibration_refresh_pending(calibration_refresh_pending));

// *** tb/spi_host_model.sv ***
// host side of the serial bus: frames of 24 bits, msb first
// assumes it is driven from the falling edge of clk
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic sdo,
    input wire logic pending,
    output logic sclk,
    output logic sync_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        int n;
        n = 0;
        while (pending !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        sync_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = w[i];
            repeat (3) @(negedge clk);
            r[i] = sdo;
            sclk = 1'b1;
            repeat (2) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (2) @(negedge clk);
        sync_n = 1'b1;
        sdi = ~sdi;
        repeat (4) @(negedge clk);
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the configuration and slew block
// assumes the host model owns the serial pins
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t %h %h", $time, a, e); end end
module testbench;
    logic clk, rst_n, sclk, sync_n, sdi, sdo, fault, tload, clr, imm, seen;
    logic [15:0] tcode, ccode, dac_code;
    logic [2:0] stp;
    logic [3:0] rte, rng;
    logic son, rset, oen, bpu, ovr, pend;
    logic [23:0] r;
    int mismatches, checks, n, t0, t1;
    wire logic [15:0] cfg = {stp, rte, son, rset, oen, bpu, ovr, rng};
    logic [3:0] rlist [10] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h0};
    logic [15:0] pat [3] = '{16'hFFF0, 16'h5550, 16'hA0A0};
    dac_output_config_slew #(.CLK_HZ(4_000_000), .CAL_REFRESH_CYCLES(4)) dut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
        .fault_pin_level(fault), .target_code(tcode), .target_load(tload),
        .clear_event(clr), .immediate_clear_on(imm), .clear_code(ccode),
        .dac_code(dac_code), .slew_step_size(stp), .slew_update_rate(rte),
        .slew_limit_on(son), .external_set_resistor_sel(rset), .output_enable(oen),
        .buffer_power_up(bpu), .voltage_overrange_on(ovr), .output_range(rng),
        .calibration_refresh_pending(pend));
    spi_host_model host (.clk(clk), .sdo(sdo), .pending(pend), .sclk(sclk),
        .sync_n(sync_n), .sdi(sdi));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pend === 1'b1) seen <= 1'b1;
    end
    task automatic give_verdict();
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [23:0] x;
        host.xfer({3'b000, a, d}, x);
    endtask
    task automatic rd(input logic [4:0] a, output logic [23:0] q);
        logic [23:0] x;
        host.xfer({3'b100, a, 16'h0000}, x);
        host.xfer(24'h00_0000, q);
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        {rst_n, fault, tload, clr, imm, seen} = 6'h00;
        tcode = 16'h0000;
        ccode = 16'h0000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK(cfg, 16'h0C00);
        fault = 1'b1;
        rd(5'h06, r);
        `CHK(r, 24'h26_0C00);
        fault = 1'b0;
        wr(5'h06, 16'h0C20);
        repeat (10050) @(negedge clk);
        foreach (pat[i]) begin
            wr(5'h06, pat[i]);
            rd(5'h06, r);
            `CHK(r, {8'h06, pat[i]});
        end
        wr(5'h05, 16'h1234);
        `CHK(cfg, 16'hA0A0);
        foreach (rlist[i]) begin
            seen = 1'b0;
            wr(5'h06, {12'hE06, rlist[i]});
            `CHK({seen, rng}, {1'b1, rlist[i]});
        end
        repeat (20) @(negedge clk);
        seen = 1'b0;
        wr(5'h06, 16'hE060);
        `CHK(seen, 1'b0);
        tcode = 16'h1000;
        tload = 1'b1;
        @(negedge clk);
        tload = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(dac_code, 16'h1000);
        wr(5'h06, 16'hE160);
        tcode = 16'h2900;
        tload = 1'b1;
        @(negedge clk);
        tload = 1'b0;
        r = {8'h00, dac_code};
        for (int c = 0; c < 200; c++) begin
            @(negedge clk);
            if (dac_code !== r[15:0]) begin
                n++;
                t1 = c;
                if (n == 1) t0 = c;
            end
            r[15:0] = dac_code;
        end
        `CHK(dac_code, 16'h2900);
        `CHK(n, 4);
        `CHK(t1 - t0, 48);
        ccode = 16'h2000;
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        `CHK(dac_code == 16'h2000, 1'b0);
        repeat (40) @(negedge clk);
        `CHK(dac_code, 16'h2000);
        imm = 1'b1;
        ccode = 16'h0123;
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        `CHK(dac_code, 16'h0123);
        give_verdict();
    end
endmodule
